/* rtl/stp_pkg.sv */
// Purpose: shared constants and carriers of the serial terminal bit port
// Assumes: command word holds device address in 7:0, order in 10:8
// Notes: register map of the event/interrupt slave lives here too
package stp_pkg;

  // peripheral command word layout
  localparam logic [7:0] STP_DEV_ADDR = 8'h07;
  localparam int STP_ADDR_LSB = 0;
  localparam int STP_ADDR_W = 8;
  localparam int STP_ORDER_LSB = 8;
  localparam int STP_ORDER_W = 3;

  // data bus bit positions
  localparam int STP_BUS_W = 16;
  localparam int STP_RX_BIT = 15;
  localparam int STP_TX_BIT = 15;
  localparam int STP_IRQ_STATUS_BIT = 7;

  // line levels and reset values
  localparam logic STP_MARK = 1'b1;
  localparam logic [15:0] STP_BUS_ZERO = 16'h0000;
  localparam logic [15:0] STP_RELEASE_N = 16'hFFFF;
  localparam logic [15:0] STP_ONE_HOT0 = 16'h0001;

  typedef enum logic [2:0] {
    STP_ORD_IDLE0 = 3'b000,
    STP_ORD_SET_IEN = 3'b001,
    STP_ORD_READ_BIT = 3'b010,
    STP_ORD_WRITE_BIT = 3'b011,
    STP_ORD_TAPE_ON = 3'b100,
    STP_ORD_RESET = 3'b101,
    STP_ORD_INT_STATUS = 3'b110,
    STP_ORD_IDLE7 = 3'b111
  } stp_order_type;

  // event/interrupt register slave
  localparam int STP_AXI_AW = 4;
  localparam logic [3:0] STP_OFF_STATUS = 4'h0;
  localparam logic [3:0] STP_OFF_CLEAR = 4'h4;
  localparam logic [3:0] STP_OFF_ENABLE = 4'h8;
  localparam logic [3:0] STP_OFF_STATE = 4'hC;
  localparam logic [1:0] STP_RESP_OKAY = 2'b00;
  localparam logic [1:0] STP_RESP_SLVERR = 2'b10;
  localparam logic [31:0] STP_WORD_ZERO = 32'h0000_0000;
  localparam int STP_EV_START = 0;
  localparam int STP_EV_TX = 1;
  localparam int STP_EV_RESET = 2;
  localparam int STP_EV_W = 3;
  localparam logic [2:0] STP_EV_NONE = 3'h0;

  typedef struct packed {
    logic valid;
    logic read;
    logic [15:0] word;
  } stp_cmd_type;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } stp_wdata_type;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
    logic [15:0] drive_n;
  } stp_rdata_type;

endpackage : stp_pkg

/* rtl/stp_serial_terminal_bit_port.sv */
// Purpose: program-controlled bit-serial terminal port on the peripheral bus
// Assumes: command and data strobes come from logic on clock
// Notes: framing and bit timing are left to software
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module stp_serial_terminal_bit_port
  import stp_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire stp_cmd_type cmd,
  input wire stp_wdata_type wdata,
  output stp_rdata_type rd,
  output logic order_accepted_flag,
  input wire logic serial_terminal_rx,
  output logic serial_terminal_tx,
  output logic tape_reader_enable,
  output logic shared_irq_request_line_n_out,
  output logic shared_irq_request_line_oe_n,
  input wire logic awvalid,
  output logic awready,
  input wire logic [STP_AXI_AW-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata_axi,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [STP_AXI_AW-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic interrupt
);

  logic rx_s1_reg, rx_s2_reg, rx_s3_reg;
  logic flag_reg, flag_next;
  logic ien_reg, ien_next;
  logic tx_reg, tx_next;
  logic tape_reg, tape_next;
  logic pending_reg, pending_next;
  logic accepted_reg, accepted_next;
  stp_rdata_type rd_reg, rd_next;
  logic [STP_EV_W-1:0] events;

  logic hit;
  stp_order_type order;
  logic wr_cmd, rd_cmd, start_seen, do_reset;

  assign hit = cmd.word[STP_ADDR_LSB +: STP_ADDR_W] == STP_DEV_ADDR;
  assign order = stp_order_type'(cmd.word[STP_ORDER_LSB +: STP_ORDER_W]);
  assign wr_cmd = cmd.valid && !cmd.read;
  assign rd_cmd = cmd.valid && cmd.read;
  // falling edge into the start bit, looked at past the synchroniser
  assign start_seen = rx_s3_reg && !rx_s2_reg;
  assign do_reset = cmd.valid && hit && order == STP_ORD_RESET;

  always_comb begin
    flag_next = flag_reg;
    ien_next = ien_reg;
    tx_next = tx_reg;
    tape_next = tape_reg;
    pending_next = pending_reg;
    accepted_next = 1'b0;
    rd_next = rd_reg;
    rd_next.valid = 1'b0;
    rd_next.drive_n = STP_RELEASE_N;
    events = STP_EV_NONE;
    // data word follows a write-bit command
    if (pending_reg && wdata.valid) begin
      tx_next = wdata.word[STP_TX_BIT];
      pending_next = 1'b0;
      events[STP_EV_TX] = 1'b1;
    end
    if (rd_cmd && order == STP_ORD_INT_STATUS) begin
      // answered whatever the address; flag left as is
      rd_next.valid = 1'b1;
      rd_next.data = STP_BUS_ZERO;
      rd_next.data[STP_IRQ_STATUS_BIT] = flag_reg;
      rd_next.drive_n = ~(STP_ONE_HOT0 << STP_IRQ_STATUS_BIT);
      accepted_next = 1'b1;
    end else if (cmd.valid && hit) begin
      unique case (order)
        STP_ORD_SET_IEN: begin
          if (wr_cmd) begin
            ien_next = 1'b1;
            accepted_next = 1'b1;
          end
        end
        STP_ORD_READ_BIT: begin
          if (rd_cmd) begin
            rd_next.valid = 1'b1;
            rd_next.data = STP_BUS_ZERO;
            rd_next.data[STP_RX_BIT] = rx_s2_reg;
            rd_next.drive_n = STP_BUS_ZERO;
            accepted_next = 1'b1;
          end
        end
        STP_ORD_WRITE_BIT: begin
          if (wr_cmd) begin
            pending_next = 1'b1;
            accepted_next = 1'b1;
          end
        end
        STP_ORD_TAPE_ON: begin
          tape_next = 1'b1;
          accepted_next = 1'b1;
        end
        STP_ORD_RESET: begin
          flag_next = 1'b0;
          ien_next = 1'b0;
          tx_next = STP_MARK;
          tape_next = 1'b0;
          pending_next = 1'b0;
          accepted_next = 1'b1;
          events[STP_EV_RESET] = 1'b1;
        end
        STP_ORD_IDLE0, STP_ORD_INT_STATUS, STP_ORD_IDLE7: begin
          // nothing to do
        end
      endcase
    end
    // a start bit in the same cycle as a reset order still counts
    if (start_seen) begin
      flag_next = 1'b1;
      events[STP_EV_START] = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_s1_reg <= STP_MARK;
      rx_s2_reg <= STP_MARK;
      rx_s3_reg <= STP_MARK;
      flag_reg <= 1'b0;
      ien_reg <= 1'b0;
      tx_reg <= STP_MARK;
      tape_reg <= 1'b0;
      pending_reg <= 1'b0;
      accepted_reg <= 1'b0;
      rd_reg <= '{valid: 1'b0, data: STP_BUS_ZERO, drive_n: STP_RELEASE_N};
    end else begin
      rx_s1_reg <= serial_terminal_rx;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      flag_reg <= flag_next;
      ien_reg <= ien_next;
      tx_reg <= tx_next;
      tape_reg <= tape_next;
      pending_reg <= pending_next;
      accepted_reg <= accepted_next;
      rd_reg <= rd_next;
    end
  end

  assign rd = rd_reg;
  assign order_accepted_flag = accepted_reg;
  assign serial_terminal_tx = tx_reg;
  assign tape_reader_enable = tape_reg;
  // pulls the shared line low only while enabled and requesting
  assign shared_irq_request_line_n_out = 1'b0;
  assign shared_irq_request_line_oe_n = !(ien_reg && flag_reg);

  // event status, enable and clear over the register slave
  logic aw_full_reg, aw_full_next;
  logic [STP_AXI_AW-1:0] aw_addr_reg, aw_addr_next;
  logic w_full_reg, w_full_next;
  logic [31:0] w_data_reg, w_data_next;
  logic w_lane0_reg, w_lane0_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [STP_EV_W-1:0] status_reg, status_next;
  logic [STP_EV_W-1:0] enable_reg, enable_next;
  logic [STP_EV_W-1:0] clear_mask;
  logic do_write;

  assign awready = !aw_full_reg;
  assign wready = !w_full_reg;
  assign arready = !rvalid_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

  always_comb begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next = w_full_reg;
    w_data_next = w_data_reg;
    w_lane0_next = w_lane0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    enable_next = enable_reg;
    clear_mask = STP_EV_NONE;
    if (awvalid && awready) begin
      aw_full_next = 1'b1;
      aw_addr_next = awaddr;
    end
    if (wvalid && wready) begin
      w_full_next = 1'b1;
      w_data_next = wdata_axi;
      w_lane0_next = wstrb[0];
    end
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = STP_RESP_OKAY;
      unique case ({aw_addr_reg[STP_AXI_AW-1:2], 2'b00})
        STP_OFF_CLEAR: begin
          if (w_lane0_reg) begin
            clear_mask = w_data_reg[STP_EV_W-1:0];
          end
        end
        STP_OFF_ENABLE: begin
          if (w_lane0_reg) begin
            enable_next = w_data_reg[STP_EV_W-1:0];
          end
        end
        STP_OFF_STATUS, STP_OFF_STATE: begin
          // read-only words, write dropped
        end
        default: begin
          bresp_next = STP_RESP_SLVERR;
        end
      endcase
    end else if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_next = 1'b1;
      rresp_next = STP_RESP_OKAY;
      rdata_next = STP_WORD_ZERO;
      unique case ({araddr[STP_AXI_AW-1:2], 2'b00})
        STP_OFF_STATUS: rdata_next[STP_EV_W-1:0] = status_reg;
        STP_OFF_ENABLE: rdata_next[STP_EV_W-1:0] = enable_reg;
        STP_OFF_STATE: begin
          rdata_next[4:0] = {tape_reg, ien_reg, flag_reg, tx_reg, rx_s2_reg};
        end
        STP_OFF_CLEAR: begin
          // write-only word reads as zero
        end
        default: rresp_next = STP_RESP_SLVERR;
      endcase
    end else if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
    // new events win over a clear in the same cycle
    status_next = (status_reg & ~clear_mask) | events;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg <= 1'b0;
      w_data_reg <= STP_WORD_ZERO;
      w_lane0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= STP_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= STP_WORD_ZERO;
      rresp_reg <= STP_RESP_OKAY;
      status_reg <= STP_EV_NONE;
      enable_reg <= STP_EV_NONE;
    end else begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg <= w_full_next;
      w_data_reg <= w_data_next;
      w_lane0_reg <= w_lane0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      status_reg <= status_next;
      enable_reg <= enable_next;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign interrupt = |(status_reg & enable_reg);

  property p_addr_filter;
    @(posedge clock) disable iff (reset)
      wr_cmd && !hit && !ien_reg |=> !ien_reg;
  endproperty
  a_addr_filter:
    assert property (p_addr_filter) else $error("foreign address acted on");

  property p_set_ien;
    @(posedge clock) disable iff (reset)
      wr_cmd && hit && order == STP_ORD_SET_IEN |=> ien_reg ##1 ien_reg;
  endproperty
  a_set_ien:
    assert property (p_set_ien) else $error("enable order lost");

  property p_start_flag;
    @(posedge clock) disable iff (reset)
      $fell(rx_s2_reg) |=> flag_reg;
  endproperty
  a_start_flag:
    assert property (p_start_flag) else $error("start bit missed");

  property p_irq_line;
    @(posedge clock) disable iff (reset)
      $rose(ien_reg) && flag_reg |-> !shared_irq_request_line_oe_n
        && shared_irq_request_line_n_out == 1'b0;
  endproperty
  a_irq_line:
    assert property (p_irq_line) else $error("request line not pulled");

  property p_read_bit;
    @(posedge clock) disable iff (reset)
      rd_cmd && hit && order == STP_ORD_READ_BIT |=> rd.valid
        && rd.data[STP_RX_BIT] == $past(rx_s2_reg) && rd.drive_n == 16'h0000
        ##1 !rd.valid;
  endproperty
  a_read_bit:
    assert property (p_read_bit) else $error("receive level not returned");

  property p_write_bit;
    @(posedge clock) disable iff (reset)
      pending_reg && wdata.valid && !do_reset
        |=> tx_reg == $past(wdata.word[STP_TX_BIT]);
  endproperty
  a_write_bit:
    assert property (p_write_bit) else $error("transmit level not loaded");

  property p_tx_hold;
    @(posedge clock) disable iff (reset)
      !pending_reg && !do_reset |=> $stable(tx_reg);
  endproperty
  a_tx_hold:
    assert property (p_tx_hold) else $error("transmit level moved");

  property p_reset_order;
    @(posedge clock) disable iff (reset)
      do_reset |=> !ien_reg && tx_reg == STP_MARK && !tape_reg
        && order_accepted_flag;
  endproperty
  a_reset_order:
    assert property (p_reset_order) else $error("reset order incomplete");

  property p_tape_on;
    @(posedge clock) disable iff (reset)
      cmd.valid && hit && order == STP_ORD_TAPE_ON |=> tape_reg;
  endproperty
  a_tape_on:
    assert property (p_tape_on) else $error("tape reader not started");

  property p_int_status;
    @(posedge clock) disable iff (reset)
      rd_cmd && order == STP_ORD_INT_STATUS |=> rd.valid
        && rd.data[STP_IRQ_STATUS_BIT] == $past(flag_reg)
        && !rd.drive_n[STP_IRQ_STATUS_BIT] && rd.drive_n[STP_RX_BIT];
  endproperty
  a_int_status:
    assert property (p_int_status) else $error("status bit wrong");

  property p_status_keeps_flag;
    @(posedge clock) disable iff (reset)
      rd_cmd && order == STP_ORD_INT_STATUS && flag_reg |=> flag_reg;
  endproperty
  a_status_keeps_flag:
    assert property (p_status_keeps_flag) else $error("status cleared flag");

  property p_idle_order;
    @(posedge clock) disable iff (reset)
      cmd.valid && hit && (order == STP_ORD_IDLE0 || order == STP_ORD_IDLE7)
        && !pending_reg && !start_seen |=> $stable(ien_reg)
        && $stable(tape_reg) && $stable(flag_reg) && !order_accepted_flag;
  endproperty
  a_idle_order:
    assert property (p_idle_order) else $error("idle order changed state");

endmodule : stp_serial_terminal_bit_port

/* tb/stp_cpu_model.sv */
// Purpose: processor model issuing peripheral orders to the port
// Assumes: each task is entered just after a rising clock edge
// Notes: keeps only the read bits that the port defines
`timescale 1ns/1ps
module stp_cpu_model
  import stp_pkg::*;
(
  input wire logic clock,
  output stp_cmd_type cmd,
  output stp_wdata_type wdata,
  input wire stp_rdata_type rd,
  input wire logic order_accepted_flag
);
  logic acc;
  logic rx_bit;
  logic irq_bit;
  logic [15:0] drv_n;

  initial begin
    cmd = '0;
    wdata = '0;
  end

  task automatic order(input logic r, input logic [2:0] o,
                       input logic [7:0] a);
    @(posedge clock);
    cmd <= '{1'b1, r, {5'h00, o, a}};
    @(posedge clock);
    // word turned over once the strobe is gone
    cmd <= '{1'b0, ~r, ~{5'h00, o, a}};
    #1;
    acc = order_accepted_flag;
    drv_n = rd.drive_n;
    rx_bit = rd.data[STP_RX_BIT];
    irq_bit = rd.data[STP_IRQ_STATUS_BIT];
  endtask : order

  task automatic data_word(input logic [15:0] w, input int gap);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    wdata <= '{1'b1, w};
    @(posedge clock);
    wdata <= '{1'b0, ~w};
    #1;
  endtask : data_word

  task automatic write_bit(input logic [15:0] w, input int gap);
    order(1'b0, STP_ORD_WRITE_BIT, STP_DEV_ADDR);
    data_word(w, gap);
  endtask : write_bit
endmodule : stp_cpu_model

/* tb/stp_serial_terminal_bit_port_test.sv */
// Purpose: self-checking bench of the serial terminal bit port
// Assumes: processor model drives the peripheral bus
// Notes: orders run from a row table, odd cases follow it
`timescale 1ns/1ps
module stp_serial_terminal_bit_port_test
  import stp_pkg::*;
  ;
  typedef struct packed {
    logic r;
    logic [2:0] o;
    logic [7:0] a;
    logic acc;
    logic [15:0] dn;
    logic tape;
  } stp_row_type;

  logic clock, reset, serial_terminal_rx, order_accepted_flag;
  stp_cmd_type cmd;
  stp_wdata_type wdata;
  stp_rdata_type rd;
  logic serial_terminal_tx, tape_reader_enable, interrupt;
  logic irq_n_out, irq_oe_n, irq_line;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata_axi, rdata, rdv;
  logic [1:0] bresp, rresp, rsp;
  logic [7:0] ch = 8'hB4;
  int err_total, total_checks, cycles;
  stp_row_type row;
  stp_row_type rows [0:16] = '{
    '{1'b0, 3'h1, 8'h07, 1'b1, 16'hFFFF, 1'b0},
    '{1'b1, 3'h1, 8'h07, 1'b0, 16'hFFFF, 1'b0},
    '{1'b1, 3'h3, 8'h07, 1'b0, 16'hFFFF, 1'b0},
    '{1'b0, 3'h2, 8'h07, 1'b0, 16'hFFFF, 1'b0},
    '{1'b0, 3'h6, 8'h07, 1'b0, 16'hFFFF, 1'b0},
    '{1'b1, 3'h0, 8'h07, 1'b0, 16'hFFFF, 1'b0},
    '{1'b1, 3'h7, 8'h07, 1'b0, 16'hFFFF, 1'b0},
    '{1'b0, 3'h0, 8'h07, 1'b0, 16'hFFFF, 1'b0},
    '{1'b0, 3'h7, 8'h07, 1'b0, 16'hFFFF, 1'b0},
    '{1'b1, 3'h2, 8'h07, 1'b1, 16'h0000, 1'b0},
    '{1'b1, 3'h2, 8'h08, 1'b0, 16'hFFFF, 1'b0},
    '{1'b1, 3'h6, 8'h3C, 1'b1, 16'hFF7F, 1'b0},
    '{1'b0, 3'h4, 8'h07, 1'b1, 16'hFFFF, 1'b1},
    '{1'b0, 3'h5, 8'h87, 1'b0, 16'hFFFF, 1'b1},
    '{1'b1, 3'h5, 8'h07, 1'b1, 16'hFFFF, 1'b0},
    '{1'b1, 3'h4, 8'h07, 1'b1, 16'hFFFF, 1'b1},
    '{1'b0, 3'h5, 8'h07, 1'b1, 16'hFFFF, 1'b0}};

  // pull-up on the shared request line
  assign irq_line = irq_oe_n ? 1'b1 : irq_n_out;

  stp_serial_terminal_bit_port u_stp_serial_terminal_bit_port (
    .clock(clock), .reset(reset), .cmd(cmd), .wdata(wdata), .rd(rd),
    .order_accepted_flag(order_accepted_flag),
    .serial_terminal_rx(serial_terminal_rx),
    .serial_terminal_tx(serial_terminal_tx),
    .tape_reader_enable(tape_reader_enable),
    .shared_irq_request_line_n_out(irq_n_out),
    .shared_irq_request_line_oe_n(irq_oe_n),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata_axi(wdata_axi),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .interrupt(interrupt));

  stp_cpu_model u_stp_cpu_model (
    .clock(clock), .cmd(cmd), .wdata(wdata), .rd(rd),
    .order_accepted_flag(order_accepted_flag));

  always #25 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task complete_run;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic bh;
    bh = 1'b0;
    @(posedge clock);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    wdata_axi <= d;
    while (!bh) begin
      @(posedge clock);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
      bh = bvalid && bready;
      if (bh) begin
        rsp = bresp;
        bready <= 1'b0;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a);
    logic rh;
    rh = 1'b0;
    @(posedge clock);
    {arvalid, rready} <= 2'h3;
    araddr <= a;
    while (!rh) begin
      @(posedge clock);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
      rh = rvalid && rready;
      if (rh) begin
        rdv = rdata;
        rsp = rresp;
        rready <= 1'b0;
      end
    end
  endtask : axi_rd

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      err_total++;
      complete_run();
    end
  end

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    serial_terminal_rx = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wstrb} = 12'h00F;
    wdata_axi = 32'h0000_0000;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    #1;
    check({serial_terminal_tx, tape_reader_enable, irq_oe_n, interrupt},
          4'hA);
    check(rd.drive_n, STP_RELEASE_N);
    axi_rd(STP_OFF_STATE);
    check(rdv, 32'h0000_0003);
    foreach (rows[i]) begin
      row = rows[i];
      u_stp_cpu_model.order(row.r, row.o, row.a);
      check(u_stp_cpu_model.acc, row.acc);
      check(tape_reader_enable, row.tape);
      if (!row.acc || (row.r && row.o[1])) begin
        check(u_stp_cpu_model.drv_n, row.dn);
      end
    end
    // one character, low bits opposite to bit 15
    for (int i = 0; i < 8; i++) begin
      u_stp_cpu_model.write_bit({ch[i], {15{~ch[i]}}}, i % 3);
      check(serial_terminal_tx, ch[i]);
      repeat (2) @(posedge clock);
      #1;
      check(serial_terminal_tx, ch[i]);
    end
    u_stp_cpu_model.write_bit(16'h7FFF, 0);
    u_stp_cpu_model.order(1'b0, 3'h3, 8'h07);
    u_stp_cpu_model.order(1'b1, 3'h5, 8'h07);
    check(serial_terminal_tx, 1'b1);
    u_stp_cpu_model.data_word(16'h0000, 0);
    check(serial_terminal_tx, 1'b1);
    // start bit while the port enable is off
    @(posedge clock);
    serial_terminal_rx <= 1'b0;
    repeat (4) @(posedge clock);
    u_stp_cpu_model.order(1'b1, 3'h6, 8'hA5);
    check(u_stp_cpu_model.irq_bit, 1'b1);
    check(irq_oe_n, 1'b1);
    u_stp_cpu_model.order(1'b1, 3'h2, 8'h07);
    check(u_stp_cpu_model.rx_bit, 1'b0);
    u_stp_cpu_model.order(1'b1, 3'h6, 8'h00);
    check(u_stp_cpu_model.irq_bit, 1'b1);
    u_stp_cpu_model.order(1'b0, 3'h1, 8'h07);
    check({irq_oe_n, irq_line}, 2'b00);
    axi_rd(STP_OFF_STATUS);
    check(rdv, 32'h0000_0007);
    axi_wr(STP_OFF_ENABLE, 32'h0000_0001);
    #1;
    check(interrupt, 1'b1);
    axi_wr(STP_OFF_ENABLE, 32'h0000_0000);
    #1;
    check(interrupt, 1'b0);
    axi_wr(STP_OFF_ENABLE, 32'h0000_0001);
    axi_wr(STP_OFF_CLEAR, 32'h0000_0001);
    #1;
    check(interrupt, 1'b0);
    axi_wr(STP_OFF_STATUS, 32'h0000_0000);
    check(rsp, STP_RESP_OKAY);
    axi_rd(STP_OFF_STATUS);
    check(rdv, 32'h0000_0006);
    @(posedge clock);
    serial_terminal_rx <= 1'b1;
    repeat (3) @(posedge clock);
    u_stp_cpu_model.order(1'b1, 3'h2, 8'h07);
    check(u_stp_cpu_model.rx_bit, 1'b1);
    u_stp_cpu_model.order(1'b1, 3'h5, 8'h07);
    u_stp_cpu_model.order(1'b1, 3'h6, 8'h07);
    check({u_stp_cpu_model.irq_bit, irq_oe_n}, 2'b01);
    // mid-run reset with the tape reader on
    u_stp_cpu_model.order(1'b0, 3'h4, 8'h07);
    check(tape_reader_enable, 1'b1);
    @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    #1;
    check({serial_terminal_tx, tape_reader_enable, irq_oe_n, interrupt},
          4'hA);
    u_stp_cpu_model.order(1'b1, 3'h2, 8'h07);
    check(u_stp_cpu_model.acc, 1'b1);
    complete_run();
  end
endmodule : stp_serial_terminal_bit_port_test
